// ---- board_io_cfg.svh ----
`ifndef BOARD_IO_CFG_SVH
`define BOARD_IO_CFG_SVH

// ----------------------------------------------------------------
// Board port map
// ----------------------------------------------------------------
`define IO_ADDR_BANK_A 16'h4145
`define IO_ADDR_BANK_B 16'h4146
`define IO_ADDR_IN_LO 16'h4160
`define IO_ADDR_IN_HI 16'h4161
`define DRV_SEL_MSB 2
`define DRV_ON_BIT 7

// ----------------------------------------------------------------
// Channel counts and limits
// ----------------------------------------------------------------
`define NUM_IN 16
`define NUM_OUT 12
`define BANK_SIZE 6
`define NUM_PWM 4
`define IN_CHAN_MAX 8'h0f
`define OUT_CHAN_MAX 8'h0b
`define PWM_CHAN_MAX 8'h03
`define IRQ_A_INPUT 6
`define IRQ_B_INPUT 7

// ----------------------------------------------------------------
// PWM timing
// ----------------------------------------------------------------
`define DUTY_FULL 9'h100
`define PWM_DIV_CLKS 120
`define PWM_DIV_LAST 7'h77
`define CLK_HZ 10000000
`define REFRESH_MS 25
`define REFRESH_DIVS ((`REFRESH_MS * `CLK_HZ / 1000) / `PWM_DIV_CLKS)

// ----------------------------------------------------------------
// Controller registers
// ----------------------------------------------------------------
`define REG_CHAN 8'h00
`define REG_VALUE 8'h04
`define REG_CMD 8'h08
`define REG_RESULT 8'h0c
`define REG_ERR 8'h10
`define REG_ITC 8'h14
`define REG_STAT 8'h18
`define REG_MASK 8'h1c
`define ERR_NODEV_BIT 0
`define RESULT_FAIL 16'hffff
`define RESULT_OK 16'h0000
`define BUSY_BIT 31
`define STAT_DONE 0
`define STAT_NODEV 1
`define STAT_PWM_STOP 2
`define STAT_IRQ_A 3
`define STAT_IRQ_B 4

`endif

// ---- board_io_pkg.sv ----
package board_io_pkg;
	typedef logic [15:0] io_addr_t;
	typedef logic [7:0] io_data_t;
	typedef logic [8:0] duty_t;
	typedef logic [1:0] pwm_chan_t;
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_EXEC = 3'b010,
		HS_READ = 3'b100
	} host_state_t;
	typedef enum logic [2:0] {
		OP_INIT = 3'h0,
		OP_DI = 3'h1,
		OP_DO = 3'h2,
		OP_DUTY = 3'h3,
		OP_PWM_INIT = 3'h4,
		OP_REFRESH = 3'h5
	} op_t;
endpackage : board_io_pkg

// ---- board_io_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface board_io_if;
	import board_io_pkg::*;
	logic ioWr;
	logic ioRd;
	io_addr_t ioAddr;
	io_data_t ioWdata;
	io_data_t ioRdata;
	logic extIrqAN;
	logic extIrqBN;
	logic pwmWr;
	pwm_chan_t pwmChan;
	duty_t pwmDuty;
	logic pwmInit;
	logic pwmRefresh;
	logic pwmStopped;
	modport dev(input ioWr, ioRd, ioAddr, ioWdata, pwmWr, pwmChan, pwmDuty,
		pwmInit, pwmRefresh, output ioRdata, extIrqAN, extIrqBN, pwmStopped);
	modport host(output ioWr, ioRd, ioAddr, ioWdata, pwmWr, pwmChan, pwmDuty,
		pwmInit, pwmRefresh, input ioRdata, extIrqAN, extIrqBN, pwmStopped);
endinterface : board_io_if
`default_nettype wire

// ---- board_io_device.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "board_io_cfg.svh"
module board_io_device (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Host link
	board_io_if.dev link,
	// Board pins
	input wire logic [`NUM_IN-1:0] inPins,
	output logic [`NUM_OUT-1:0] outDrv
);
	import board_io_pkg::*;

	// ------------------------------------------------------------
	// Input pins
	// ------------------------------------------------------------
	logic [`NUM_IN-1:0] inMeta_q;
	logic [`NUM_IN-1:0] inSync_q;
	io_data_t rdata_q;
	wire io_data_t rdata_d = !link.ioRd ? 8'h00 :
		(link.ioAddr == `IO_ADDR_IN_LO) ? inSync_q[7:0] :
		(link.ioAddr == `IO_ADDR_IN_HI) ? inSync_q[15:8] : 8'h00;

	always_ff @(posedge core_clk) begin
		inMeta_q <= inPins;
		inSync_q <= inMeta_q;
		rdata_q <= sys_rst ? 8'h00 : rdata_d;
	end
	assign link.ioRdata = rdata_q;
	// Inputs 6 and 7 double as the active-low interrupt lines
	assign link.extIrqAN = inSync_q[`IRQ_A_INPUT];
	assign link.extIrqBN = inSync_q[`IRQ_B_INPUT];

	// ------------------------------------------------------------
	// PWM timebase and DMA count
	// ------------------------------------------------------------
	logic pwmRun_q;
	logic [6:0] divClk_q;
	logic [9:0] divNum_q;
	logic [11:0] dmaCount_q;
	wire logic divTick = (divClk_q == `PWM_DIV_LAST);
	wire logic dmaEmpty = (dmaCount_q == 12'h000);
	wire logic pwmLive = pwmRun_q && !dmaEmpty;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pwmRun_q <= 1'b0;
			divClk_q <= 7'h00;
			divNum_q <= 10'h000;
			dmaCount_q <= 12'h000;
		end else begin
			pwmRun_q <= pwmRun_q | link.pwmInit;
			divClk_q <= divTick ? 7'h00 : divClk_q + 7'h01;
			if (divTick)
				divNum_q <= divNum_q + 10'h001;
			// Without a refresh the count runs out and PWM stops
			if (link.pwmInit || link.pwmRefresh)
				dmaCount_q <= 12'(`REFRESH_DIVS);
			else if (divTick && pwmRun_q && !dmaEmpty)
				dmaCount_q <= dmaCount_q - 12'h001;
		end
	end
	assign link.pwmStopped = !pwmLive;

	// ------------------------------------------------------------
	// Output drivers and PWM channels
	// ------------------------------------------------------------
	wire logic bankA = link.ioWr && (link.ioAddr == `IO_ADDR_BANK_A);
	wire logic bankB = link.ioWr && (link.ioAddr == `IO_ADDR_BANK_B);
	wire logic [2:0] drvSel = link.ioWdata[`DRV_SEL_MSB:0];
	wire logic drvOn = link.ioWdata[`DRV_ON_BIT];
	logic [`NUM_OUT-1:0] drvOn_q;
	logic [`NUM_PWM-1:0] pwmUsed_q;
	logic [`NUM_PWM-1:0] pwmBit;

	genvar i;
	generate
		for (i = 0; i < `NUM_OUT; i++) begin : g_out
			// Selects 6 and 7 name no driver and change nothing
			wire logic hit = (i < `BANK_SIZE) ?
				(bankA && drvSel == 3'(i)) :
				(bankB && drvSel == 3'(i - `BANK_SIZE));
			wire logic level;
			if (i < `NUM_PWM) begin : g_pwm
				// Channel i lags channel 0 by i divisions
				wire logic [9:0] phase = divNum_q - 10'(i);
				duty_t dutyNew_q;
				duty_t dutyCur_q;
				wire logic sel = link.pwmWr && link.pwmChan == 2'(i);
				always_ff @(posedge core_clk) begin
					if (sys_rst) begin
						dutyNew_q <= 9'h000;
						dutyCur_q <= 9'h000;
						pwmUsed_q[i] <= 1'b0;
					end else begin
						// Duty writes before PWM init are dropped
						if (sel && pwmRun_q)
							dutyNew_q <= (link.pwmDuty > `DUTY_FULL) ?
								`DUTY_FULL : link.pwmDuty;
						// New duty only at this channel's period start
						if (divTick && phase == 10'h3ff)
							dutyCur_q <= dutyNew_q;
						if (sel && pwmRun_q)
							pwmUsed_q[i] <= 1'b1;
						else if (hit)
							pwmUsed_q[i] <= 1'b0;
					end
				end
				assign pwmBit[i] = {1'b0, phase[9:2]} < dutyCur_q;
				assign level = (pwmUsed_q[i] && pwmLive) ?
					pwmBit[i] : drvOn_q[i];
			end else begin : g_plain
				assign level = drvOn_q[i];
			end
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					drvOn_q[i] <= 1'b0;
					outDrv[i] <= 1'b0;
				end else begin
					if (hit)
						drvOn_q[i] <= drvOn;
					outDrv[i] <= level;
				end
			end
		end
	endgenerate
endmodule : board_io_device
`default_nettype wire

// ---- board_io_host.sv ----
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "board_io_cfg.svh"
module board_io_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Device link
	board_io_if.host link,
	// Software port
	input wire logic [7:0] swAddr,
	input wire logic [31:0] swWdata,
	input wire logic swWr,
	input wire logic swRd,
	output logic [31:0] swRdata,
	// Interrupt
	output logic irq
);
	import board_io_pkg::*;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	host_state_t state_q;
	op_t op_q;
	logic [7:0] chan_q;
	logic [8:0] value_q;
	logic [15:0] result_q;
	logic [7:0] err_q;
	logic [1:0] itc_q;
	logic [4:0] stat_q;
	logic [4:0] mask_q;
	logic stopPrev_q;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire logic idle = (state_q == HS_IDLE);
	wire logic exec = (state_q == HS_EXEC);
	wire logic wrCmd = swWr && swAddr == `REG_CMD && idle;
	// The routine runs while the line is held low and enabled
	wire logic irqA = itc_q[0] && !link.extIrqAN;
	wire logic irqB = itc_q[1] && !link.extIrqBN;
	wire logic isrHold = irqA || irqB;
	wire logic go = exec && !isrHold;
	wire logic badChan = (op_q == OP_DI) ? (chan_q > `IN_CHAN_MAX) :
		(op_q == OP_DO) ? (chan_q > `OUT_CHAN_MAX) :
		(op_q == OP_DUTY) ? (chan_q > `PWM_CHAN_MAX) : 1'b0;
	wire logic bad = go && badChan;
	wire logic good = go && !badChan;
	wire logic inBankB = chan_q >= 8'(`BANK_SIZE);
	wire logic [7:0] bankIdx = inBankB ? chan_q - 8'(`BANK_SIZE) : chan_q;

	// Link strobes follow the state; the data come from registers
	assign link.ioRd = good && op_q == OP_DI;
	assign link.ioWr = good && op_q == OP_DO;
	assign link.ioAddr = (op_q == OP_DI) ?
		(chan_q[3] ? `IO_ADDR_IN_HI : `IO_ADDR_IN_LO) :
		(inBankB ? `IO_ADDR_BANK_B : `IO_ADDR_BANK_A);
	assign link.ioWdata = {value_q[0], 4'h0, bankIdx[2:0]};
	assign link.pwmWr = good && op_q == OP_DUTY;
	assign link.pwmChan = chan_q[1:0];
	assign link.pwmDuty = value_q;
	assign link.pwmInit = good && op_q == OP_PWM_INIT;
	assign link.pwmRefresh = good && op_q == OP_REFRESH;

	wire logic readDone = (state_q == HS_READ);
	wire logic [15:0] readBit = {15'h0000, link.ioRdata[chan_q[2:0]]};
	wire logic [15:0] goodRes = (op_q == OP_REFRESH && link.pwmStopped) ?
		`RESULT_FAIL : `RESULT_OK;
	wire logic [4:0] events = {irqB, irqA,
		link.pwmStopped && !stopPrev_q, bad,
		(go && !link.ioRd) || readDone};
	wire logic rdStat = swRd && swAddr == `REG_STAT;
	wire logic [4:0] stat_d = (rdStat ? 5'h00 : stat_q) | events;
	wire logic [31:0] rdMux =
		(swAddr == `REG_CHAN) ? {24'h000000, chan_q} :
		(swAddr == `REG_VALUE) ? {23'h000000, value_q} :
		(swAddr == `REG_CMD) ? {29'h00000000, op_q} :
		(swAddr == `REG_RESULT) ? {!idle, 15'h0000, result_q} :
		(swAddr == `REG_ERR) ? {24'h000000, err_q} :
		(swAddr == `REG_ITC) ? {30'h00000000, itc_q} :
		(swAddr == `REG_STAT) ? {27'h0000000, stat_q} :
		(swAddr == `REG_MASK) ? {27'h0000000, mask_q} : 32'h00000000;

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= HS_IDLE;
			op_q <= OP_INIT;
			result_q <= `RESULT_OK;
		end else begin
			unique case (state_q)
				HS_IDLE: begin
					if (wrCmd) begin
						op_q <= op_t'(swWdata[2:0]);
						state_q <= HS_EXEC;
					end
				end
				HS_EXEC: begin
					if (bad) begin
						result_q <= `RESULT_FAIL;
						state_q <= HS_IDLE;
					end else if (good) begin
						result_q <= goodRes;
						state_q <= link.ioRd ? HS_READ : HS_IDLE;
					end
				end
				HS_READ: begin
					result_q <= readBit;
					state_q <= HS_IDLE;
				end
				default: state_q <= HS_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			chan_q <= 8'h00;
			value_q <= 9'h000;
			err_q <= 8'h00;
			itc_q <= 2'h0;
			stat_q <= 5'h00;
			mask_q <= 5'h00;
			stopPrev_q <= 1'b1;
			swRdata <= 32'h00000000;
		end else begin
			if (swWr && swAddr == `REG_CHAN)
				chan_q <= swWdata[7:0];
			if (swWr && swAddr == `REG_VALUE)
				value_q <= swWdata[8:0];
			if (swWr && swAddr == `REG_ITC)
				itc_q <= swWdata[1:0];
			if (swWr && swAddr == `REG_MASK)
				mask_q <= swWdata[4:0];
			// An invalid access is never lost to a clear
			if (bad)
				err_q <= err_q | 8'h01;
			else if (good && op_q == OP_INIT)
				err_q <= 8'h00;
			else if (swWr && swAddr == `REG_ERR)
				err_q <= swWdata[7:0];
			stat_q <= stat_d;
			stopPrev_q <= link.pwmStopped;
			swRdata <= swRd ? rdMux : 32'h00000000;
		end
	end
	assign irq = |(stat_q & mask_q);
endmodule : board_io_host
`default_nettype wire

// ---- board_io_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module board_io_assertions (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Link
	input wire logic ioWr,
	input wire logic ioRd,
	input wire board_io_pkg::io_addr_t ioAddr,
	input wire board_io_pkg::io_data_t ioWdata,
	input wire board_io_pkg::io_data_t ioRdata,
	input wire logic pwmWr,
	input wire board_io_pkg::duty_t pwmDuty,
	input wire logic pwmInit,
	input wire logic pwmRefresh,
	input wire logic pwmStopped
);
	import board_io_pkg::*;
	// ----------------------------------------
	// Link rules
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence sCmd;
		ioWr || ioRd || pwmWr || pwmInit || pwmRefresh;
	endsequence
	sequence sQuiet;
		!(ioWr || ioRd || pwmWr || pwmInit || pwmRefresh);
	endsequence
	a_rd_addr_ok: assert property (ioRd |-> ioAddr inside {16'h4160, 16'h4161})
		else $error("input read at bad port");
	a_wr_addr_ok: assert property (ioWr |-> ioAddr inside {16'h4145, 16'h4146})
		else $error("output write at bad port");
	a_wr_sel_ok: assert property (ioWr |-> ioWdata[2:0] < 3'h6)
		else $error("driver select out of bank");
	a_rd_data_idle: assert property ($past(ioRd) || ioRdata == 8'h00)
		else $error("read data outside its cycle");
	a_cmd_spacing: assert property (sCmd |=> sQuiet)
		else $error("link commands back to back");
	a_one_cmd: assert property ($onehot0({ioWr, ioRd, pwmWr, pwmInit, pwmRefresh}))
		else $error("two link commands at once");
	a_duty_max: assert property (pwmWr |-> pwmDuty <= 9'h100)
		else $error("duty above full scale");
	a_init_runs: assert property (pwmInit |-> ##[1:4] !pwmStopped)
		else $error("pwm not running after init");
endmodule : board_io_assertions
`default_nettype wire

// ---- board_io_pwm_interrupts_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "board_io_cfg.svh"
module board_io_pwm_interrupts_tb_top;
	import board_io_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] inPins = 16'hffff;
	logic [11:0] outDrv;
	logic [7:0] swAddr = 8'h00;
	logic [31:0] swWdata = 32'h0;
	logic swWr = 1'b0;
	logic swRd = 1'b0;
	logic [31:0] swRdata;
	logic irq;
	logic [31:0] r;
	logic [11:0] expOut = 12'h000;
	int failCount = 0;
	int nChecks = 0;
	int cycles = 0;
	int n;
	board_io_if link_if();
	board_io_device board_io_device_i(.core_clk(core_clk), .sys_rst(sys_rst),
		.link(link_if), .inPins(inPins), .outDrv(outDrv));
	board_io_host board_io_host_i(.core_clk(core_clk), .sys_rst(sys_rst),
		.link(link_if), .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr),
		.swRd(swRd), .swRdata(swRdata), .irq(irq));
	board_io_assertions board_io_assertions_i(.core_clk(core_clk),
		.sys_rst(sys_rst), .ioWr(link_if.ioWr), .ioRd(link_if.ioRd),
		.ioAddr(link_if.ioAddr), .ioWdata(link_if.ioWdata),
		.ioRdata(link_if.ioRdata), .pwmWr(link_if.pwmWr),
		.pwmDuty(link_if.pwmDuty), .pwmInit(link_if.pwmInit),
		.pwmRefresh(link_if.pwmRefresh), .pwmStopped(link_if.pwmStopped));
	always #50 core_clk = ~core_clk;
	// One full pwm period is 122880 cycles, so the ceiling sits above it
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 200000) begin
			failCount++;
			stop_test();
		end
	end
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			failCount++;
			$display("wrong value at %0h: %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		swAddr <= a;
		swWdata <= d;
		swWr <= 1'b1;
		@(posedge core_clk);
		swWr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		swAddr <= a;
		swRd <= 1'b1;
		@(posedge core_clk);
		swRd <= 1'b0;
		#1 r = swRdata;
		@(posedge core_clk);
	endtask : rd
	task automatic cmd(input op_t op, input logic [31:0] ch, input logic [31:0] v);
		wr(`REG_CHAN, ch);
		wr(`REG_VALUE, v);
		wr(`REG_CMD, {29'h0, op});
		n = 0;
		do begin
			rd(`REG_RESULT);
			n++;
		end while (r[31] !== 1'b0 && n < 40);
	endtask : cmd
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask : tick
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_inputs();
		inPins <= 16'ha5c3;
		tick(4);
		for (int i = 0; i < 16; i++) begin
			cmd(OP_DI, i, 0);
			chk(r, {31'h0, inPins[i]});
		end
		for (int i = 0; i < 2; i++) begin
			cmd(OP_DI, i ? 255 : 16, 0);
			chk(r, 32'hffff);
			rd(`REG_ERR);
			chk(r, 32'h1);
			cmd(OP_INIT, 0, 0);
			rd(`REG_ERR);
			chk(r, 32'h0);
		end
	endtask : t_inputs
	task automatic t_outputs();
		for (int i = 0; i < 13; i++) begin
			cmd(OP_DO, i, i % 2);
			chk(r, i < 12 ? 32'h0 : 32'hffff);
			tick(2);
			if (i < 12) expOut[i] = i % 2;
			chk({20'h0, outDrv}, {20'h0, expOut});
		end
		rd(`REG_ERR);
		chk(r, 32'h1);
		cmd(OP_INIT, 0, 0);
	endtask : t_outputs
	task automatic t_irq(input int i);
		wr(`REG_MASK, 32'h18);
		wr(`REG_ITC, 32'h1 << i);
		inPins <= 16'hffff & ~(16'h0001 << (7 - i));
		tick(6);
		rd(`REG_STAT);
		rd(`REG_STAT);
		chk({31'h0, irq}, 32'h0);
		inPins[7 - i] <= 1'b1;
		inPins[6 + i] <= 1'b0;
		tick(6);
		chk({31'h0, irq}, 32'h1);
		wr(`REG_CMD, {29'h0, OP_DI});
		tick(6);
		rd(`REG_RESULT);
		chk({31'h0, r[31]}, 32'h1);
		inPins[6 + i] <= 1'b1;
		tick(8);
		rd(`REG_RESULT);
		chk(r, 32'h1);
		rd(`REG_STAT);
		rd(`REG_STAT);
		chk({31'h0, irq}, 32'h0);
		wr(`REG_ITC, 32'h0);
	endtask : t_irq
	task automatic t_pwm();
		cmd(OP_REFRESH, 0, 0);
		chk(r, 32'hffff);
		// The duty written before PWM init is dropped; the high time checked below is for duty 2
		cmd(OP_DUTY, 0, 4);
		cmd(OP_PWM_INIT, 0, 0);
		cmd(OP_REFRESH, 0, 0);
		chk(r, 32'h0);
		cmd(OP_DUTY, 0, 2);
		cmd(OP_DUTY, 1, 256);
		chk({30'h0, outDrv[1:0]}, 32'h0);
		n = 0;
		while (outDrv[0] !== 1'b1 && n < 130000) begin
			@(posedge core_clk);
			#1 n++;
		end
		n = 0;
		while (outDrv[0] === 1'b1 && n < 2000) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk(n, 960);
		chk({31'h0, outDrv[1]}, 32'h1);
	endtask : t_pwm
	task automatic stop_test();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	initial begin
		tick(8);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		rd(`REG_ERR);
		chk(r, 32'h0);
		rd(`REG_ITC);
		chk(r, 32'h0);
		rd(8'h20);
		chk(r, 32'h0);
		chk({20'h0, outDrv}, 32'h0);
		t_inputs();
		t_outputs();
		t_irq(0);
		t_irq(1);
		t_pwm();
		stop_test();
	end
endmodule : board_io_pwm_interrupts_tb_top
`default_nettype wire
